// ===== fixed_reference_control.sv
// Fixed voltage reference control register bank with Wishbone slave
//
// Summary of operation
// - Bit 7 switches reference on and off
// - Ready sets only after reference settles
// - Bits 3-2 set comparator/DAC buffer gain
// - Two independent gain amplifiers, 1x 2x 4x
// - Bit 4 picks high or low range
// - Writable control bits reset to zero
// - Ready is read-only, reflects settling state
// - Oscillator or brown-out settings force reference
// - Bit 5 enables temperature indicator
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fixed_reference_regs.svh"

module fixed_reference_control
  import fixed_reference_pkg::*;
#(
  parameter int REF_SETTLE_CYC = `FRC_REF_SETTLE_CYC,
  parameter int BUF_SETTLE_CYC = `FRC_BUF_SETTLE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Device state feeding the forced-on logic
  input  wire logic        sleep_i,
  // Analog control
  output logic             ref_on_o,
  output logic             ref_ready_o,
  output logic             temp_enable_o,
  output logic             temp_high_range_o,
  output logic [1:0]       adc_gain_o,
  output logic [1:0]       cd_gain_o,
  output logic             adc_buf_ready_o,
  output logic             cd_buf_ready_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic       ref_enable_r;
  logic       temp_enable_r;
  temp_range_e temp_range_r;
  gain_code_e cd_gain_r;
  gain_code_e adc_gain_r;
  logic [2:0] osc_source_r;
  logic [3:0] intosc_freq_r;
  logic [1:0] brownout_mode_r;
  logic       brownout_fast_r;
  logic       regulator_mode_r;
  logic [`FRC_EV_WIDTH-1:0] status_r;
  logic [`FRC_EV_WIDTH-1:0] mask_r;
  ref_state_e ref_state_r;
  logic       forced_r;
  logic       ref_done;
  logic       adc_done;
  logic       cd_done;
  logic       ref_ready_r;
  logic       adc_ready_r;
  logic       cd_ready_r;
  logic       forced_prev_r;

  logic       bus_req;
  logic       wr_req;
  logic       ref_active;
  logic       forced_nxt;
  logic [7:0] ctrl_read;
  logic [31:0] read_nxt;
  logic [`FRC_EV_WIDTH-1:0] events;

  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_req  = bus_req && we_i;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Ready bit is never stored from the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_enable_r  <= 1'b0;
      temp_enable_r <= 1'b0;
      temp_range_r  <= TEMP_LOW_RANGE;
      cd_gain_r     <= GAIN_OFF;
      adc_gain_r    <= GAIN_OFF;
    end else if (wr_req && adr_i == `FRC_CTRL_OFFSET && sel_i[0]) begin
      ref_enable_r  <= dat_i[`FRC_REF_EN_BIT];
      temp_enable_r <= dat_i[`FRC_TEMP_EN_BIT];
      temp_range_r  <= temp_range_e'(dat_i[`FRC_TEMP_RNG_BIT]);
      cd_gain_r     <= gain_code_e'(
        dat_i[`FRC_CD_GAIN_HI:`FRC_CD_GAIN_LO]);
      adc_gain_r    <= gain_code_e'(
        dat_i[`FRC_ADC_GAIN_HI:`FRC_ADC_GAIN_LO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System configuration register (oscillator and brown-out settings)
  // Regulator mode bit is only stored and read back

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {regulator_mode_r, brownout_fast_r, brownout_mode_r,
       intosc_freq_r, osc_source_r} <= 11'(`FRC_SYSCFG_RESET);
    end else if (wr_req && adr_i == `FRC_SYSCFG_OFFSET) begin
      if (sel_i[0]) begin
        osc_source_r  <= dat_i[2:0];
        intosc_freq_r <= dat_i[7:4];
      end
      if (sel_i[1]) begin
        brownout_mode_r  <= dat_i[9:8];
        brownout_fast_r  <= dat_i[10];
        regulator_mode_r <= dat_i[11];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forced-on request from clock and brown-out settings

  always_comb begin
    forced_nxt = 1'b0;
    // Internal oscillator at a frequency code of 2 or above and awake
    if (osc_source_r == `FRC_OSC_INTERNAL && intosc_freq_r[3:1] != 3'h0
        && !sleep_i) begin
      forced_nxt = 1'b1;
    end
    if (brownout_mode_r == `FRC_BOR_ALWAYS) begin
      forced_nxt = 1'b1;
    end
    if ((brownout_mode_r == `FRC_BOR_NO_SLEEP ||
         brownout_mode_r == `FRC_BOR_SOFTWARE) && brownout_fast_r) begin
      forced_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      forced_r      <= 1'b0;
      forced_prev_r <= 1'b0;
    end else begin
      forced_r      <= forced_nxt;
      forced_prev_r <= forced_r;
    end
  end

  assign ref_active = ref_enable_r || forced_r;

  ////////////////////////////////////////////////////////////////////////////
  // Reference settling

  settle_timer #(
    .COUNT (REF_SETTLE_CYC)
  ) u_ref_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (ref_active),
    .done_o (ref_done)
  );

  // Buffers settle on their own timers even with the reference running
  settle_timer #(
    .COUNT (BUF_SETTLE_CYC)
  ) u_adc_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (ref_active && adc_gain_r != GAIN_OFF),
    .done_o (adc_done)
  );

  settle_timer #(
    .COUNT (BUF_SETTLE_CYC)
  ) u_cd_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (ref_active && cd_gain_r != GAIN_OFF),
    .done_o (cd_done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_state_r <= REF_OFF;
    end else begin
      unique case (ref_state_r)
        REF_OFF: begin
          if (ref_active) begin
            ref_state_r <= REF_SETTLING;
          end
        end
        REF_SETTLING: begin
          if (!ref_active) begin
            ref_state_r <= REF_OFF;
          end else if (ref_done) begin
            ref_state_r <= REF_READY;
          end
        end
        REF_READY: begin
          if (!ref_active) begin
            ref_state_r <= REF_OFF;
          end
        end
      endcase
    end
  end

  // Ready tracks settling, never a stored software value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ready_r <= 1'b0;
      adc_ready_r <= 1'b0;
      cd_ready_r  <= 1'b0;
    end else begin
      ref_ready_r <= ref_enable_r && ref_active &&
                     ref_state_r == REF_READY;
      adc_ready_r <= adc_done;
      cd_ready_r  <= cd_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog control outputs

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_on_o          <= 1'b0;
      ref_ready_o       <= 1'b0;
      temp_enable_o     <= 1'b0;
      temp_high_range_o <= 1'b0;
      adc_gain_o        <= GAIN_OFF;
      cd_gain_o         <= GAIN_OFF;
      adc_buf_ready_o   <= 1'b0;
      cd_buf_ready_o    <= 1'b0;
    end else begin
      ref_on_o          <= ref_active;
      ref_ready_o       <= ref_ready_r;
      temp_enable_o     <= temp_enable_r;
      temp_high_range_o <= (temp_range_r == TEMP_HIGH_RANGE);
      // Two amplifiers driven apart, each gated by the reference
      adc_gain_o        <= ref_active ? adc_gain_r : GAIN_OFF;
      cd_gain_o         <= ref_active ? cd_gain_r : GAIN_OFF;
      adc_buf_ready_o   <= adc_ready_r;
      cd_buf_ready_o    <= cd_ready_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  // Rising edge of the ready bit, so enabling an already settled
  // forced reference still raises the event
  assign events[`FRC_EV_READY]         = ref_enable_r && ref_active &&
                                         ref_state_r == REF_READY &&
                                         !ref_ready_r;
  assign events[`FRC_EV_ADC_BUF_READY] = adc_done && !adc_ready_r;
  assign events[`FRC_EV_CD_BUF_READY]  = cd_done && !cd_ready_r;
  assign events[`FRC_EV_FORCED]        = forced_r && !forced_prev_r;

  // Set wins over a write-one clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `FRC_EV_WIDTH; gi++) begin : g_status
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          status_r[gi] <= 1'b0;
        end else if (events[gi]) begin
          status_r[gi] <= 1'b1;
        end else if (wr_req && adr_i == `FRC_STATUS_OFFSET && sel_i[0]
                     && dat_i[gi]) begin
          status_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= '0;
    end else if (wr_req && adr_i == `FRC_MASK_OFFSET && sel_i[0]) begin
      mask_r <= dat_i[`FRC_EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read and acknowledge

  always_comb begin
    ctrl_read = 8'h00;
    ctrl_read[`FRC_REF_EN_BIT]   = ref_enable_r;
    ctrl_read[`FRC_REF_RDY_BIT]  = ref_ready_r;
    ctrl_read[`FRC_TEMP_EN_BIT]  = temp_enable_r;
    ctrl_read[`FRC_TEMP_RNG_BIT] = temp_range_r;
    ctrl_read[`FRC_CD_GAIN_HI:`FRC_CD_GAIN_LO]   = cd_gain_r;
    ctrl_read[`FRC_ADC_GAIN_HI:`FRC_ADC_GAIN_LO] = adc_gain_r;
  end

  // Unmapped addresses acknowledge and read zero
  always_comb begin
    read_nxt = 32'h0000_0000;
    unique case (adr_i)
      `FRC_CTRL_OFFSET:   read_nxt[7:0] = ctrl_read;
      `FRC_STATUS_OFFSET: read_nxt[`FRC_EV_WIDTH-1:0] = status_r;
      `FRC_MASK_OFFSET:   read_nxt[`FRC_EV_WIDTH-1:0] = mask_r;
      `FRC_SYSCFG_OFFSET: read_nxt[11:0] = {regulator_mode_r,
                            brownout_fast_r, brownout_mode_r,
                            intosc_freq_r, 1'b0, osc_source_r};
      default:            read_nxt = 32'h0000_0000;
    endcase
  end

  // Ack gates the next take, so a held strobe is served every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= (bus_req && !we_i) ? read_nxt : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ===== fixed_reference_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FIXED_REFERENCE_REGS_SVH
`define FIXED_REFERENCE_REGS_SVH

`define FRC_CTRL_OFFSET      8'h00
`define FRC_STATUS_OFFSET    8'h04
`define FRC_MASK_OFFSET      8'h08
`define FRC_SYSCFG_OFFSET    8'h0c

`define FRC_REF_EN_BIT       7
`define FRC_REF_RDY_BIT      6
`define FRC_TEMP_EN_BIT      5
`define FRC_TEMP_RNG_BIT     4
`define FRC_CD_GAIN_HI       3
`define FRC_CD_GAIN_LO       2
`define FRC_ADC_GAIN_HI      1
`define FRC_ADC_GAIN_LO      0

`define FRC_CTRL_RESET       8'h00
`define FRC_SYSCFG_RESET     16'h0000

// Event bits in status and mask
`define FRC_EV_READY         0
`define FRC_EV_ADC_BUF_READY 1
`define FRC_EV_CD_BUF_READY  2
`define FRC_EV_FORCED        3
`define FRC_EV_WIDTH         4

// Settling times
`define FRC_CLK_MHZ          100
`define FRC_REF_SETTLE_US    25
`define FRC_BUF_SETTLE_US    30
`define FRC_REF_SETTLE_CYC   (`FRC_REF_SETTLE_US * `FRC_CLK_MHZ)
`define FRC_BUF_SETTLE_CYC   (`FRC_BUF_SETTLE_US * `FRC_CLK_MHZ)

// Codes in the system configuration register
`define FRC_OSC_INTERNAL     3'b100
`define FRC_BOR_ALWAYS       2'b11
`define FRC_BOR_NO_SLEEP     2'b10
`define FRC_BOR_SOFTWARE     2'b01

`endif

// ===== fixed_reference_pkg.sv
// Types shared by the fixed reference control block
package fixed_reference_pkg;

  typedef enum logic [1:0] {
    GAIN_OFF = 2'b00,
    GAIN_1X  = 2'b01,
    GAIN_2X  = 2'b10,
    GAIN_4X  = 2'b11
  } gain_code_e;

  typedef enum logic {
    TEMP_LOW_RANGE  = 1'b0,
    TEMP_HIGH_RANGE = 1'b1
  } temp_range_e;

  typedef enum {
    REF_OFF,
    REF_SETTLING,
    REF_READY
  } ref_state_e;

endpackage

// ===== settle_timer.sv
// Down counter that reports when a settling interval has elapsed
`timescale 1ns/1ps
`default_nettype none

module settle_timer #(
  parameter int COUNT = 3000,
  parameter int WIDTH = $clog2(COUNT + 1)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      done_o
);

  logic [WIDTH-1:0] count_r;

  // Any drop of run restarts the full interval
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count_r <= WIDTH'(COUNT);
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (count_r == '0);
    end
  end

endmodule

`default_nettype wire

// ===== fixed_reference_control_sva.sv
// Port-level assertions for the fixed reference control block
`timescale 1ns/1ps
`default_nettype none

module fixed_reference_control_sva #(
  parameter int REF_SETTLE_CYC = 2500,
  parameter int BUF_SETTLE_CYC = 3000
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sleep_i,
  input wire logic        ref_on_o,
  input wire logic        ref_ready_o,
  input wire logic        temp_enable_o,
  input wire logic        temp_high_range_o,
  input wire logic [1:0]  adc_gain_o,
  input wire logic [1:0]  cd_gain_o,
  input wire logic        adc_buf_ready_o,
  input wire logic        cd_buf_ready_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////
  // Run lengths; a forced reference counts too, so ready may come late
  int on_cnt;
  int adc_cnt;
  int cd_cnt;

  always_ff @(posedge clk_i) begin
    on_cnt <= (rst_i || !ref_on_o) ? 0 : on_cnt + 1;
  end

  always_ff @(posedge clk_i) begin
    adc_cnt <= (rst_i || !ref_on_o || adc_gain_o == 2'h0) ? 0 : adc_cnt + 1;
  end

  always_ff @(posedge clk_i) begin
    cd_cnt <= (rst_i || !ref_on_o || cd_gain_o == 2'h0) ? 0 : cd_cnt + 1;
  end

  ////////////////////////////////////////
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_LATENCY: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_READY_SETTLED: assert property (
    $rose(ref_ready_o) |-> on_cnt >= REF_SETTLE_CYC)
    else $error("ready before reference settled");
  AST_READY_OFF: assert property (!ref_on_o [*3] |-> !ref_ready_o)
    else $error("ready while reference off");
  AST_ADC_SETTLED: assert property (
    $rose(adc_buf_ready_o) |-> adc_cnt >= BUF_SETTLE_CYC - 2)
    else $error("converter buffer ready too early");
  AST_CD_SETTLED: assert property (
    $rose(cd_buf_ready_o) |-> cd_cnt >= BUF_SETTLE_CYC - 2)
    else $error("comparator buffer ready too early");
  AST_TEMP_BY_WRITE: assert property (
    $changed({temp_enable_o, temp_high_range_o}) |->
      $past(ack_o) || $past(ack_o, 2))
    else $error("temperature control changed without a write");

  COV_READY: cover property ($rose(ref_ready_o));
  COV_ADC_BUF: cover property ($rose(adc_buf_ready_o));
  COV_IRQ: cover property ($rose(irq_o));
endmodule

bind fixed_reference_control fixed_reference_control_sva #(
  .REF_SETTLE_CYC(REF_SETTLE_CYC),
  .BUF_SETTLE_CYC(BUF_SETTLE_CYC)
) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i), .ref_on_o(ref_on_o),
  .ref_ready_o(ref_ready_o), .temp_enable_o(temp_enable_o),
  .temp_high_range_o(temp_high_range_o), .adc_gain_o(adc_gain_o),
  .cd_gain_o(cd_gain_o), .adc_buf_ready_o(adc_buf_ready_o),
  .cd_buf_ready_o(cd_buf_ready_o), .irq_o(irq_o)
);

`default_nettype wire

// ===== fixed_reference_control_bench.sv
// Self-checking bench for the fixed reference control block
`timescale 1ns/1ps
`default_nettype none
`include "fixed_reference_regs.svh"

module fixed_reference_control_bench;
  localparam int REF = 200;
  localparam int BUF = 300;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, sleep_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic        ack_o, ref_on_o, ref_ready_o, temp_enable_o, irq_o;
  logic        temp_high_range_o, adc_buf_ready_o, cd_buf_ready_o;
  logic [1:0]  adc_gain_o, cd_gain_o, g;
  int          num_errors, samples_checked, n;

  fixed_reference_control #(.REF_SETTLE_CYC(REF), .BUF_SETTLE_CYC(BUF)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i), .ref_on_o(ref_on_o),
    .ref_ready_o(ref_ready_o), .temp_enable_o(temp_enable_o),
    .temp_high_range_o(temp_high_range_o), .adc_gain_o(adc_gain_o),
    .cd_gain_o(cd_gain_o), .adc_buf_ready_o(adc_buf_ready_o),
    .cd_buf_ready_o(cd_buf_ready_o), .irq_o(irq_o));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is seen; data taken at that same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'hf, a, d};
    n = 0;
    // No wait limit here; only the watchdog ends a hung transfer
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    rd = dat_o;
    chk(n, 2);
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask

  task automatic wait_on(input int lim, ref logic s);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    chk({ref_on_o, ref_ready_o, temp_enable_o, adc_gain_o, cd_gain_o}, 0);
    wb(1'b0, `FRC_CTRL_OFFSET, 0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h10, 0);
    chk(rd, 32'h0);
  endtask

  // Bit 6 written high each time; it must never stick
  task automatic t_fields();
    for (int i = 0; i < 4; i++) begin
      g = i[1:0];
      wb(1'b1, `FRC_CTRL_OFFSET, {24'h0, 2'b11, g, g, ~g});
      repeat (3) @(posedge clk_i);
      chk({temp_enable_o, temp_high_range_o, cd_gain_o, adc_gain_o},
          {g, g, ~g});
      wb(1'b0, `FRC_CTRL_OFFSET, 0);
      chk(rd, {24'h0, 2'b10, g, g, ~g});
    end
    wb(1'b1, `FRC_CTRL_OFFSET, 0);
  endtask

  task automatic t_ready();
    wb(1'b1, `FRC_MASK_OFFSET, 32'h1);
    wb(1'b1, `FRC_CTRL_OFFSET, 32'h83);
    @(posedge clk_i);
    chk(ref_on_o, 1'b1);
    wait_on(REF + 40, ref_ready_o);
    chk(n >= REF - 8 && ref_ready_o, 1'b1);
    wb(1'b0, `FRC_CTRL_OFFSET, 0);
    chk(rd, 32'hc3);
    chk(irq_o, 1'b1);
    wb(1'b1, `FRC_MASK_OFFSET, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wait_on(BUF + 40, adc_buf_ready_o);
    chk({adc_buf_ready_o, cd_buf_ready_o}, 2'b10);
    // Second buffer settles on its own while the reference keeps running
    wb(1'b1, `FRC_CTRL_OFFSET, 32'h8b);
    wait_on(BUF + 40, cd_buf_ready_o);
    chk(n >= BUF - 8 && adc_buf_ready_o && cd_buf_ready_o, 1'b1);
    wb(1'b0, `FRC_STATUS_OFFSET, 0);
    chk(rd[2:0], 3'b111);
    wb(1'b1, `FRC_MASK_OFFSET, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1'b1, `FRC_STATUS_OFFSET, 32'hf);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wb(1'b1, `FRC_CTRL_OFFSET, 0);
    repeat (3) @(posedge clk_i);
    chk({ref_on_o, ref_ready_o, adc_gain_o, cd_gain_o}, 0);
  endtask

  // Sleep plus config word, and whether the reference must be forced
  logic [16:0] cfg[8] = '{17'h00300, 17'h00200, 17'h00600, 17'h00500,
                          17'h00024, 17'h10024, 17'h00014, 17'h00400};
  logic        on_x[8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  task automatic t_force();
    for (int i = 0; i < 8; i++) begin
      sleep_i <= cfg[i][16];
      wb(1'b1, `FRC_SYSCFG_OFFSET, {16'h0, cfg[i][15:0]});
      repeat (4) @(posedge clk_i);
      chk(ref_on_o, on_x[i]);
      chk(ref_ready_o, 1'b0);
    end
    // Forced reference settles, yet ready waits for the enable bit
    wb(1'b1, `FRC_SYSCFG_OFFSET, 32'h300);
    repeat (REF + 10) @(posedge clk_i);
    chk({ref_on_o, ref_ready_o}, 2'b10);
    wb(1'b1, `FRC_CTRL_OFFSET, 32'h80);
    repeat (2) @(posedge clk_i);
    chk({ref_ready_o, irq_o}, 2'b11);
    wb(1'b0, `FRC_STATUS_OFFSET, 0);
    chk(rd[3:0], 4'h9);
    wb(1'b1, `FRC_STATUS_OFFSET, 32'hf);
    wb(1'b1, `FRC_CTRL_OFFSET, 0);
    wb(1'b1, `FRC_SYSCFG_OFFSET, 0);
  endtask

  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  initial begin
    {rst_i, cyc_i, stb_i, we_i, sleep_i} <= 5'h10;
    {adr_i, sel_i, dat_i} <= {8'h0, 4'hf, 32'h0};
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_ready();
    t_force();
    give_verdict();
  end
endmodule

`default_nettype wire
